/* File: rtl/mss_mail_send.sv */
`timescale 1ns/10ps
module mss_mail_send #(
   parameter int NUM_ST = 64
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // software writes
   input wire logic ctrl_wr,
   input wire logic [mss_pkg::REG_W-1:0] ctrl_wdata,
   input wire logic limit_wr,
   input wire logic [mss_pkg::REG_W-1:0] limit_wdata,
   input wire logic err_clr_wr,
   // software reads
   output logic [mss_pkg::REG_W-1:0] send_control_reg,
   output logic [mss_pkg::REG_W-1:0] send_time_limit_reg,
   output logic [mss_pkg::REG_W-1:0] send_error_status_reg,
   output logic [mss_pkg::REG_W-1:0] send_result_reg,
   output logic status_send_error,
   output logic send_done,
   output logic [7:0] est_cycles,
   // own station and network timing
   input wire logic [mss_pkg::STA_W-1:0] own_station_address,
   input wire logic own_running,
   input wire logic cycle_tick,
   input wire logic mail_slot,
   input wire logic [NUM_ST-1:0] peer_starts,
   // destination state seen on the network
   input wire logic dest_present,
   input wire logic dest_running,
   input wire logic dest_io_mode,
   input wire logic dest_owned_by_other,
   input wire logic dest_rx_ready,
   input wire logic dest_busy,
   // packet link
   output logic [mss_pkg::STA_W-1:0] station_address,
   output logic mail_request,
   output logic pkt_send,
   output logic [mss_pkg::SIZE_W-1:0] pkt_unit,
   input wire logic pkt_ack,
   input wire logic pkt_nak
);

   typedef struct packed {
      mss_pkg::mss_state_type state;
      logic [mss_pkg::STA_W-1:0] dest;
      logic [mss_pkg::SIZE_W-1:0] size;
      logic send;
      logic [mss_pkg::LIMIT_W-1:0] limit;
      logic [mss_pkg::ERR_N-1:0] errs;
      logic [mss_pkg::LIMIT_W-1:0] cyc;
      logic [mss_pkg::LIMIT_W-1:0] result;
      logic [1:0] retry;
      logic [mss_pkg::SIZE_W-1:0] unit;
      logic done;
      logic pkt;
      logic [7:0] est;
   } mss_regs_type;

   mss_regs_type st_q;
   mss_regs_type st_d;
   logic [NUM_ST-1:0] contenders;
   logic [NUM_ST-1:0] grant;
   logic dest_ok;
   logic win;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic size_ok(input logic [mss_pkg::SIZE_W-1:0] s);
      return (s >= mss_pkg::SIZE_MIN) && (s <= mss_pkg::SIZE_MAX);
   endfunction

   function automatic logic limit_ok(
      input logic [mss_pkg::LIMIT_W-1:0] l);
      return l >= mss_pkg::LIMIT_MIN;
   endfunction

   // guide figure only; waiting and resends are not included
   function automatic logic [7:0] est_of(
      input logic [mss_pkg::SIZE_W-1:0] s);
      int bytes;
      bytes = int'(s) * mss_pkg::UNIT_BYTES;
      return 8'((bytes + mss_pkg::EST_ROUND) / mss_pkg::UNIT_BYTES
                + mss_pkg::EST_OVERHEAD);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // arbitration among stations starting in the same cycle

   // a destination that cannot take mail never enters contention
   assign dest_ok = dest_present && dest_running && !dest_owned_by_other
                    && !dest_io_mode && dest_rx_ready;

   always_comb begin
      contenders = peer_starts;
      if (st_q.state == mss_pkg::ST_WAIT && dest_ok && !dest_busy) begin
         contenders[own_station_address] = 1'b1;
      end
   end

   mss_arbiter #(
      .NUM_ST(NUM_ST),
      .IDX_W(mss_pkg::STA_W)
   ) u_arb (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .advance(cycle_tick),
      .requests(contenders),
      .grant(grant)
   );

   assign win = cycle_tick && grant[own_station_address];

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic fin;
      logic [mss_pkg::ERR_N-1:0] fail;
      logic [mss_pkg::LIMIT_W-1:0] cyc_n;
      fin = 1'b0;
      fail = '0;
      cyc_n = st_q.cyc;
      st_d = st_q;
      st_d.done = 1'b0;
      st_d.pkt = 1'b0;

      // clear first so a failure landing in the same cycle still sets
      if (err_clr_wr) begin
         st_d.errs = '0;
      end
      if (limit_wr) begin
         st_d.limit = limit_wdata[mss_pkg::LIMIT_W-1:0];
      end
      if (cycle_tick && st_q.state != mss_pkg::ST_IDLE
          && st_q.cyc != '1) begin
         cyc_n = st_q.cyc + 1'b1;
      end
      st_d.cyc = cyc_n;

      case (st_q.state)
         mss_pkg::ST_IDLE: begin
            // fields are write-protected while a send runs
            if (ctrl_wr) begin
               st_d.dest = ctrl_wdata[mss_pkg::CTL_DST_LSB +: mss_pkg::STA_W];
               st_d.size = ctrl_wdata[mss_pkg::CTL_SIZE_LSB +:
                                      mss_pkg::SIZE_W];
               // guide kept in a flop so the output is not an adder
               st_d.est = est_of(st_d.size);
            end
            if (ctrl_wr && ctrl_wdata[mss_pkg::CTL_SEND_BIT]) begin
               st_d.cyc = '0;
               cyc_n = '0;
               st_d.retry = '0;
               st_d.unit = '0;
               if (!size_ok(ctrl_wdata[mss_pkg::CTL_SIZE_LSB +:
                                       mss_pkg::SIZE_W])) begin
                  fin = 1'b1;
                  fail[mss_pkg::ERR_SIZE] = 1'b1;
               end else if (!limit_ok(st_q.limit)) begin
                  fin = 1'b1;
                  fail[mss_pkg::ERR_LIMIT] = 1'b1;
               end else begin
                  st_d.send = 1'b1;
                  st_d.state = mss_pkg::ST_WAIT;
               end
            end
         end
         mss_pkg::ST_WAIT,
         mss_pkg::ST_XFER,
         mss_pkg::ST_ACK: begin
            if (!own_running) begin
               fin = 1'b1;
               fail[mss_pkg::ERR_STOP] = 1'b1;
            end else if (cyc_n >= st_q.limit) begin
               fin = 1'b1;
               fail[mss_pkg::ERR_TIME] = 1'b1;
            end else if (st_q.state == mss_pkg::ST_WAIT) begin
               if (!dest_present || !dest_running
                   || dest_owned_by_other) begin
                  fin = 1'b1;
                  fail[mss_pkg::ERR_ABSENT] = 1'b1;
               end else if (dest_io_mode || !dest_rx_ready) begin
                  fin = 1'b1;
                  fail[mss_pkg::ERR_NOT_READY] = 1'b1;
               end else if (win) begin
                  st_d.state = mss_pkg::ST_XFER;
               end
            end else if (st_q.state == mss_pkg::ST_XFER) begin
               // only the mail slot of a cycle carries mail packets
               if (mail_slot) begin
                  st_d.pkt = 1'b1;
                  st_d.state = mss_pkg::ST_ACK;
               end
            end else if (pkt_ack) begin
               st_d.retry = '0;
               if (st_q.unit + 1'b1 == st_q.size) begin
                  fin = 1'b1;
               end else begin
                  st_d.unit = st_q.unit + 1'b1;
                  st_d.state = mss_pkg::ST_XFER;
               end
            end else if (pkt_nak) begin
               if (st_q.retry == mss_pkg::RESEND_MAX) begin
                  fin = 1'b1;
                  fail[mss_pkg::ERR_ABSENT] = 1'b1;
               end else begin
                  st_d.retry = st_q.retry + 1'b1;
                  st_d.state = mss_pkg::ST_XFER;
               end
            end
         end
         default: begin
            st_d.state = mss_pkg::ST_IDLE;
            st_d.send = 1'b0;
         end
      endcase

      if (fin) begin
         st_d.state = mss_pkg::ST_IDLE;
         st_d.send = 1'b0;
         st_d.done = 1'b1;
         st_d.result = cyc_n;
         st_d.errs = st_d.errs | fail;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register; enable low freezes everything
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q.state <= mss_pkg::ST_IDLE;
         st_q.dest <= '0;
         st_q.size <= '0;
         st_q.send <= 1'b0;
         st_q.limit <= mss_pkg::LIMIT_RST;
         st_q.errs <= '0;
         st_q.cyc <= '0;
         st_q.result <= '0;
         st_q.retry <= '0;
         st_q.unit <= '0;
         st_q.done <= 1'b0;
         st_q.pkt <= 1'b0;
         st_q.est <= 8'(mss_pkg::EST_OVERHEAD); // guide for size zero
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs; error summaries follow the error bits, no sticky copy
   always_comb begin
      send_control_reg = '0;
      send_control_reg[mss_pkg::CTL_ERR_BIT] = |st_q.errs;
      send_control_reg[mss_pkg::CTL_SEND_BIT] = st_q.send;
      send_control_reg[mss_pkg::CTL_DST_LSB +: mss_pkg::STA_W] = st_q.dest;
      send_control_reg[mss_pkg::CTL_SIZE_LSB +: mss_pkg::SIZE_W] = st_q.size;
      send_time_limit_reg = '0;
      send_time_limit_reg[mss_pkg::LIMIT_W-1:0] = st_q.limit;
      send_error_status_reg = '0;
      send_error_status_reg[mss_pkg::ERR_N-1:0] = st_q.errs;
      send_result_reg = '0;
      send_result_reg[mss_pkg::LIMIT_W-1:0] = st_q.result;
   end

   assign status_send_error = |st_q.errs;
   assign send_done = st_q.done;
   assign est_cycles = st_q.est;
   assign station_address = st_q.dest;
   assign mail_request = (st_q.state == mss_pkg::ST_WAIT);
   assign pkt_send = st_q.pkt;
   assign pkt_unit = st_q.unit;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_summary_tracks_errs: assert property (
      status_send_error == (|send_error_status_reg)
      && send_control_reg[mss_pkg::CTL_ERR_BIT] == status_send_error)
      else $error("summary bits differ from error bits");

   a_clear_wipes_errs: assert property (
      ce && err_clr_wr && !st_d.done |=> send_error_status_reg == '0)
      else $error("error write did not clear errors");

   a_bad_size_faults: assert property (
      ce && st_q.state == mss_pkg::ST_IDLE && ctrl_wr
      && ctrl_wdata[mss_pkg::CTL_SEND_BIT]
      && !size_ok(ctrl_wdata[mss_pkg::CTL_SIZE_LSB +: mss_pkg::SIZE_W])
      |=> send_error_status_reg[mss_pkg::ERR_SIZE] && send_done && !st_q.send)
      else $error("bad size not faulted");

   a_bad_limit_faults: assert property (
      ce && st_q.state == mss_pkg::ST_IDLE && ctrl_wr
      && ctrl_wdata[mss_pkg::CTL_SEND_BIT] && st_q.limit == '0
      && size_ok(ctrl_wdata[mss_pkg::CTL_SIZE_LSB +: mss_pkg::SIZE_W])
      |=> send_error_status_reg[mss_pkg::ERR_LIMIT])
      else $error("zero limit not faulted");

   a_stop_aborts: assert property (
      ce && st_q.state != mss_pkg::ST_IDLE && !own_running
      |=> st_q.state == mss_pkg::ST_IDLE && send_done
      && send_error_status_reg[mss_pkg::ERR_STOP])
      else $error("send not stopped");

   a_send_bit_clears: assert property (
      $fell(st_q.send) |-> send_done)
      else $error("send bit fell without completion");

   a_pkt_in_slot: assert property (
      ce && st_d.pkt |-> mail_slot && st_q.state == mss_pkg::ST_XFER)
      else $error("packet outside mail slot");

   a_resend_bound: assert property (
      ce && st_q.state == mss_pkg::ST_ACK && pkt_nak && own_running
      && st_q.retry == mss_pkg::RESEND_MAX && st_q.cyc < st_q.limit
      && !(cycle_tick && st_q.cyc + 1'b1 >= st_q.limit)
      |=> send_error_status_reg[mss_pkg::ERR_ABSENT] && !st_q.send)
      else $error("fourth failure not absent");

   a_result_holds: assert property (
      !send_done |=> send_done || $stable(send_result_reg))
      else $error("result changed without completion");

   c_send_ok: cover property (
      $fell(st_q.send) && !status_send_error);
   c_send_resend: cover property (
      st_q.state == mss_pkg::ST_ACK && pkt_nak ##1 st_q.retry != '0);
   c_send_timeout: cover property (
      send_done && send_error_status_reg[mss_pkg::ERR_TIME]);

endmodule // mss_mail_send

/* File: rtl/mss_pkg.sv */
package mss_pkg;
   // widths of the software-visible fields
   localparam int STA_W = 6;
   localparam int SIZE_W = 6;
   localparam int LIMIT_W = 13;
   localparam int REG_W = 16;

   // send control register layout
   localparam int CTL_ERR_BIT = 15;
   localparam int CTL_SEND_BIT = 14;
   localparam int CTL_DST_LSB = 8;
   localparam int CTL_SIZE_LSB = 0;

   // error status bit positions
   localparam int ERR_NOT_READY = 0;
   localparam int ERR_ABSENT = 1;
   localparam int ERR_TIME = 2;
   localparam int ERR_SIZE = 3;
   localparam int ERR_LIMIT = 4;
   localparam int ERR_STOP = 5;
   localparam int ERR_N = 6;

   // reset values and legal ranges
   localparam logic [LIMIT_W-1:0] LIMIT_RST = 13'h1fff;
   localparam logic [LIMIT_W-1:0] LIMIT_MIN = 13'h0001;
   localparam logic [SIZE_W-1:0] SIZE_MIN = 6'h01;
   localparam logic [SIZE_W-1:0] SIZE_MAX = 6'h20;

   // transfer figures
   localparam logic [1:0] RESEND_MAX = 2'h3;
   localparam int UNIT_BYTES = 8;
   localparam int EST_ROUND = 7;
   localparam int EST_OVERHEAD = 3;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_WAIT = 4'h2,
      ST_XFER = 4'h4,
      ST_ACK = 4'h8
   } mss_state_type;
endpackage

/* File: rtl/mss_arbiter.sv */
`timescale 1ns/10ps
// rotating-priority pick among stations starting mail in the same cycle
module mss_arbiter #(
   parameter int NUM_ST = 64,
   parameter int IDX_W = 6
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // contention
   input wire logic advance,
   input wire logic [NUM_ST-1:0] requests,
   output logic [NUM_ST-1:0] grant
);

   typedef struct packed {
      logic [IDX_W-1:0] ptr;
   } mss_arb_type;

   mss_arb_type st_q;
   mss_arb_type st_d;
   logic [IDX_W-1:0] win_idx;
   logic found;

   ////////////////////////////////////////////////////////////////////////
   // lowest address from the pointer upward wins, then pointer moves past
   // the winner so a steady low-address sender cannot starve the rest
   always_comb begin
      logic [IDX_W-1:0] idx;
      idx = '0;
      st_d = st_q;
      grant = '0;
      found = 1'b0;
      win_idx = '0;
      for (int i = 0; i < NUM_ST; i++) begin
         idx = IDX_W'((int'(st_q.ptr) + i) % NUM_ST);
         if (!found && requests[idx]) begin
            found = 1'b1;
            win_idx = idx;
         end
      end
      if (found) begin
         grant[win_idx] = 1'b1;
      end
      if (advance && found) begin
         st_d.ptr = IDX_W'((int'(win_idx) + 1) % NUM_ST);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   a_arb_one_grant: assert property (@(posedge clk) disable iff (rst)
      $onehot0(grant)) else $error("arbiter grants more than one");

endmodule // mss_arbiter

/* File: tb/mss_peer_model.sv */
`timescale 1ns/10ps
// far-side stations: network cycle timing and packet answers
module mss_peer_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // behaviour chosen by the bench
   input wire logic load,
   input wire logic [2:0] nak_budget,
   input wire logic [3:0] ans_delay,
   // packet link
   input wire logic pkt_send,
   output logic pkt_ack,
   output logic pkt_nak,
   // network timing
   output logic cycle_tick,
   output logic mail_slot
);
   logic [2:0] tick_q;
   logic [3:0] wait_q;
   logic pend_q;
   logic [2:0] naks_q;

   ////////////////////////////////////////////////////////////////////////
   // one answer per packet; naks first so resends can be provoked
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_q <= 3'h0;
         wait_q <= 4'h0;
         pend_q <= 1'b0;
         naks_q <= 3'h0;
         pkt_ack <= 1'b0;
         pkt_nak <= 1'b0;
      end else begin
         tick_q <= tick_q + 3'h1;
         pkt_ack <= 1'b0;
         pkt_nak <= 1'b0;
         if (load) begin
            naks_q <= nak_budget;
         end
         if (pkt_send) begin
            pend_q <= 1'b1;
            wait_q <= ans_delay;
         end else if (pend_q && wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
         end else if (pend_q && naks_q != 3'h0) begin
            pend_q <= 1'b0;
            pkt_nak <= 1'b1; // transfer trouble
            naks_q <= naks_q - 3'h1;
         end else if (pend_q) begin
            pend_q <= 1'b0;
            pkt_ack <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // slot 0 of each cycle belongs to the shared-memory exchange
   assign cycle_tick = (tick_q == 3'h7);
   assign mail_slot = (tick_q != 3'h0);
endmodule // mss_peer_model

/* File: tb/tb.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
   $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb;
   ////////////////////////////////////////////////////////////////////////
   // stimulus and observed signals
   int err_total = 0;
   int comparisons = 0;
   int cyc = 0;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1;
   logic ctrl_wr = 1'b0, limit_wr = 1'b0, err_clr_wr = 1'b0, load = 1'b0;
   logic [15:0] ctrl_wdata = 16'h0000, limit_wdata = 16'h0000;
   logic [2:0] nak_budget = 3'h0;
   logic [3:0] ans_delay = 4'h0;
   logic own_running = 1'b1, dest_present = 1'b1, dest_running = 1'b1;
   logic dest_io_mode = 1'b0, dest_owned_by_other = 1'b0;
   logic dest_rx_ready = 1'b1, dest_busy = 1'b0;
   logic [63:0] peer_starts = 64'h0;
   logic [15:0] ctl_r, lim_r, err_r, res_r;
   logic status_send_error, send_done, mail_request, pkt_send;
   logic pkt_ack, pkt_nak, cycle_tick, mail_slot;
   logic [7:0] est_cycles;
   logic [5:0] station_address, pkt_unit;

   // 40 ns clock
   always #20 clk = ~clk;

   mss_mail_send DUT (.clk(clk), .rst(rst), .ce(ce), .ctrl_wr(ctrl_wr),
      .ctrl_wdata(ctrl_wdata), .limit_wr(limit_wr), .limit_wdata(limit_wdata),
      .err_clr_wr(err_clr_wr), .send_control_reg(ctl_r),
      .send_time_limit_reg(lim_r), .send_error_status_reg(err_r),
      .send_result_reg(res_r), .status_send_error(status_send_error),
      .send_done(send_done), .est_cycles(est_cycles),
      .own_station_address(6'h05), .own_running(own_running),
      .cycle_tick(cycle_tick), .mail_slot(mail_slot),
      .peer_starts(peer_starts), .dest_present(dest_present),
      .dest_running(dest_running), .dest_io_mode(dest_io_mode),
      .dest_owned_by_other(dest_owned_by_other),
      .dest_rx_ready(dest_rx_ready), .dest_busy(dest_busy),
      .station_address(station_address), .mail_request(mail_request),
      .pkt_send(pkt_send), .pkt_unit(pkt_unit), .pkt_ack(pkt_ack),
      .pkt_nak(pkt_nak));

   mss_peer_model peer (.clk(clk), .rst(rst), .load(load),
      .nak_budget(nak_budget), .ans_delay(ans_delay), .pkt_send(pkt_send),
      .pkt_ack(pkt_ack), .pkt_nak(pkt_nak), .cycle_tick(cycle_tick),
      .mail_slot(mail_slot));

   ////////////////////////////////////////////////////////////////////////
   // shared bus-cycle helpers
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic kick(input logic [5:0] dst, input logic [5:0] sz);
      @(posedge clk);
      ctrl_wr <= 1'b1;
      ctrl_wdata <= {2'b01, dst, 2'b00, sz};
      @(posedge clk);
      ctrl_wr <= 1'b0;
   endtask

   task automatic set_limit(input logic [12:0] v);
      @(posedge clk);
      limit_wr <= 1'b1;
      limit_wdata <= {3'h0, v};
      @(posedge clk);
      limit_wr <= 1'b0;
   endtask

   // bounded wait so a stuck send cannot hang the run
   task automatic wait_done;
      int n;
      n = 0;
      while (send_done !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      `CHK(send_done, 1'b1)
   endtask

   task automatic expect_err(input int b);
      `CHK(err_r, 16'h0001 << b)
      `CHK(ctl_r[15], 1'b1)
      `CHK(status_send_error, 1'b1)
      `CHK(ctl_r[14], 1'b0)
      @(posedge clk);
      err_clr_wr <= 1'b1;
      @(posedge clk);
      err_clr_wr <= 1'b0;
      @(posedge clk);
      `CHK(err_r, 16'h0000)
      `CHK({ctl_r[15], status_send_error}, 2'b00)
   endtask

   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset;
      `CHK(err_r, 16'h0000)
      `CHK({ctl_r[15:14], status_send_error}, 3'h0)
      `CHK(lim_r, 16'h1fff)
      `CHK(res_r, 16'h0000)
   endtask

   task automatic t_size;
      kick(6'h02, 6'h00);
      wait_done;
      expect_err(mss_pkg::ERR_SIZE);
      kick(6'h02, 6'h21);
      wait_done;
      expect_err(mss_pkg::ERR_SIZE);
      kick(6'h02, 6'h20);
      wait_done;
      `CHK(err_r, 16'h0000)
   endtask

   task automatic t_limit;
      set_limit(13'h0000);
      kick(6'h02, 6'h01);
      wait_done;
      expect_err(mss_pkg::ERR_LIMIT);
      set_limit(13'h0100);
      @(posedge clk);
      `CHK(lim_r, 16'h0100)
   endtask

   // counts units on the link of a five-unit mail
   task automatic t_good;
      logic [5:0] u;
      int n;
      u = 6'h00;
      n = 0;
      kick(6'h02, 6'h05); // peer 2 is a shared-memory station
      #1;
      `CHK(est_cycles, 8'h08)
      `CHK(ctl_r[14], 1'b1)
      while (send_done !== 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
         if (pkt_send === 1'b1) begin
            `CHK(pkt_unit, u)
            `CHK(station_address, 6'h02)
            u++;
         end
      end
      `CHK(u, 6'h05)
      `CHK(err_r, 16'h0000)
      `CHK(res_r != 16'h0000, 1'b1)
      `CHK(ctl_r[14], 1'b0)
   endtask

   // one row per faulty destination condition
   task automatic t_dest;
      for (int i = 0; i < 5; i++) begin
         dest_rx_ready <= (i != 0);
         dest_io_mode <= (i == 1);
         dest_present <= (i != 2);
         dest_running <= (i != 3);
         dest_owned_by_other <= (i == 4);
         kick(6'h03, 6'h01);
         wait_done;
         if (i < 2) expect_err(mss_pkg::ERR_NOT_READY);
         else expect_err(mss_pkg::ERR_ABSENT);
      end
      dest_rx_ready <= 1'b1;
      dest_owned_by_other <= 1'b0;
   endtask

   task automatic t_wait;
      dest_busy <= 1'b1;
      kick(6'h03, 6'h01);
      kick(6'h09, 6'h01);
      repeat (20) @(posedge clk);
      `CHK(mail_request, 1'b1)
      `CHK(ctl_r[13:8], 6'h03)
      // enable low: the now free send must not move at all
      ce <= 1'b0;
      dest_busy <= 1'b0;
      repeat (24) @(posedge clk);
      `CHK(ctl_r[14], 1'b1)
      ce <= 1'b1;
      wait_done;
      `CHK(err_r, 16'h0000)
   endtask

   task automatic t_time_stop;
      set_limit(13'h0001);
      dest_busy <= 1'b1;
      kick(6'h03, 6'h01);
      wait_done;
      expect_err(mss_pkg::ERR_TIME);
      set_limit(13'h0100);
      kick(6'h03, 6'h01);
      repeat (20) @(posedge clk);
      own_running <= 1'b0;
      wait_done;
      expect_err(mss_pkg::ERR_STOP);
      own_running <= 1'b1;
      dest_busy <= 1'b0;
   endtask

   // three resends still succeed, a fourth failure gives up
   task automatic t_retry;
      for (int k = 3; k < 5; k++) begin
         nak_budget <= k[2:0];
         ans_delay <= 4'h5;
         load <= 1'b1;
         @(posedge clk);
         load <= 1'b0;
         kick(6'h02, 6'h01);
         wait_done;
         if (k == 3) `CHK(err_r, 16'h0000)
         else expect_err(mss_pkg::ERR_ABSENT);
      end
      ans_delay <= 4'h0;
   endtask

   // pointer sits past our address, so station 1 must win the first
   // contested cycle and we the next one
   task automatic t_arb;
      kick(6'h02, 6'h01);
      peer_starts <= 64'h2;
      @(posedge clk);
      while (cycle_tick !== 1'b1) @(posedge clk);
      @(posedge clk);
      `CHK(mail_request, 1'b1)
      wait_done;
      `CHK(err_r, 16'h0000)
      peer_starts <= 64'h0;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         wrap_up;
      end
   end

   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_size;
      t_limit;
      t_good;
      t_dest;
      t_wait;
      t_time_stop;
      t_retry;
      t_arb;
      wrap_up;
   end
endmodule // tb
